// ---- hw/gpp_port.sv ----
// Port pins with per-pin interrupts and three pin interrupt channels
`timescale 1ns/1ps
// Behaviour
// - each pin has its own direction bit
// - set/clear aliases change only written-one pins
// - per-pin mask gates port interrupt
// - inputs by hardware, outputs by software request
// - level or edge, rising or both edges
// - pin interrupts edge or level, programmable polarity
// - pin interrupts ignore direction and data
// - three channels, 32 pins each
// - half ports of eight assigned to channels
// - each channel has 32-bit register set
// - pin states and latches readable when masked
// - set and clear aliases for direction, output data, interrupt enable and channel mask, edge and polarity registers
module gpp_port
  import gpp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] pin_in,
  output logic [31:0]      pin_out,
  output logic [31:0]      pin_oe_n,
  output logic             gpio_irq,
  output logic [2:0]       pin_irq_channels
);

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic             wr_en;
  logic             rd_setup;
  logic             hit;
  logic [31:0]      rdata;
  logic [31:0]      prdata_ff;
  logic             in_page;
  logic [1:0]       ch_idx;
  logic [5:0]       ch_off;

  // Writes land at the access edge; reads are sampled at setup
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign in_page  = (paddr[11:8] == GPP_PINT_PAGE)
                  && (paddr[7:6] != GPP_CH_NONE);
  assign ch_idx   = paddr[7:6];
  assign ch_off   = paddr[5:0];
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = prdata_ff;

  // ***************************************************************
  // Port state
  // ***************************************************************
  logic [31:0]      dir_ff;
  logic [31:0]      dout_ff;
  logic [31:0]      pin_q_ff;
  logic [31:0]      stat_ff;
  logic [31:0]      en_ff;
  logic [31:0]      sedge_ff;
  logic [31:0]      sboth_ff;
  logic [31:0]      pol_ff;
  logic [7:0]       assign_ff;
  logic [31:0]      gevt;
  logic [31:0]      nxt_stat;
  logic [31:0]      stat_clr;
  logic [31:0]      sw_req;

  // Direction with set and clear aliases
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_ff <= GPP_RST_WORD;
    end else if (wr_en) begin
      case (paddr)
        GPP_DIR:     dir_ff <= pwdata;
        GPP_DIR_SET: dir_ff <= dir_ff | pwdata;
        GPP_DIR_CLR: dir_ff <= dir_ff & ~pwdata;
        default:     dir_ff <= dir_ff;
      endcase
    end
  end

  // Output data with set, clear and toggle aliases
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_ff <= GPP_RST_WORD;
    end else if (wr_en) begin
      case (paddr)
        GPP_DOUT:     dout_ff <= pwdata;
        GPP_DOUT_SET: dout_ff <= dout_ff | pwdata;
        GPP_DOUT_CLR: dout_ff <= dout_ff & ~pwdata;
        GPP_DOUT_TGL: dout_ff <= dout_ff ^ pwdata;
        default:      dout_ff <= dout_ff;
      endcase
    end
  end

  // Pin drivers; enable low while driving
  assign pin_out  = dout_ff;
  assign pin_oe_n = ~dir_ff;

  // Previous pin sample for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q_ff <= GPP_RST_WORD;
    end else begin
      pin_q_ff <= pin_in;
    end
  end

  // Enable, sensitivity and polarity settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_ff    <= GPP_RST_WORD;
      sedge_ff <= GPP_RST_WORD;
      sboth_ff <= GPP_RST_WORD;
      pol_ff   <= GPP_RST_WORD;
    end else if (wr_en) begin
      case (paddr)
        GPP_IRQ_EN:     en_ff    <= pwdata;
        GPP_IRQ_EN_SET: en_ff    <= en_ff | pwdata;
        GPP_IRQ_EN_CLR: en_ff    <= en_ff & ~pwdata;
        GPP_SENS_EDGE:  sedge_ff <= pwdata;
        GPP_SENS_BOTH:  sboth_ff <= pwdata;
        GPP_POL:        pol_ff   <= pwdata;
        default:        en_ff    <= en_ff;
      endcase
    end
  end

  // Half-port to channel map, two bits per half port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      assign_ff <= GPP_RST_ASSIGN;
    end else if (wr_en && paddr == GPP_ASSIGN) begin
      assign_ff <= pwdata[7:0];
    end
  end

  // Port event detectors and per-pin channel membership
  logic [31:0]      pm_ff   [GPP_NCH];
  logic [31:0]      pl_ff   [GPP_NCH];
  logic [31:0]      pe_ff   [GPP_NCH];
  logic [31:0]      pi_ff   [GPP_NCH];
  logic [31:0]      pevt    [GPP_NCH];
  logic [31:0]      member  [GPP_NCH];

  for (genvar i = 0; i < GPP_PINS; i++) begin : g_pin
    gpp_pin_evt u_gevt (
      .pin_now    (pin_in[i]),
      .pin_prev   (pin_q_ff[i]),
      .invert     (pol_ff[i]),
      .edge_mode  (sedge_ff[i]),
      .both_edges (sboth_ff[i]),
      .evt        (gevt[i])
    );
    for (genvar c = 0; c < GPP_NCH; c++) begin : g_ch
      assign member[c][i] =
        (assign_ff[2*(i/GPP_HALF) +: 2] == 2'(c));
      gpp_pin_evt u_pevt (
        .pin_now    (pin_in[i]),
        .pin_prev   (pin_q_ff[i]),
        .invert     (pi_ff[c][i]),
        .edge_mode  (pe_ff[c][i]),
        .both_edges (1'b0),
        .evt        (pevt[c][i])
      );
    end
  end

  // ***************************************************************
  // Port interrupt status
  // ***************************************************************
  // Inputs by hardware, outputs only by software; set beats clear
  always_comb begin
    stat_clr = (wr_en && paddr == GPP_IRQ_CLR) ? pwdata : GPP_RST_WORD;
    sw_req   = (wr_en && paddr == GPP_SWREQ) ? pwdata : GPP_RST_WORD;
    nxt_stat = (stat_ff & ~stat_clr) | (gevt & ~dir_ff)
             | (sw_req & dir_ff);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_ff <= GPP_RST_WORD;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Level interrupt while any enabled bit stands
  assign gpio_irq = |(stat_ff & en_ff);

  // ***************************************************************
  // Pin interrupt channels
  // ***************************************************************
  for (genvar c = 0; c < GPP_NCH; c++) begin : g_chan
    logic        cw;
    logic [31:0] lat_clr;

    assign cw      = wr_en && in_page && ch_idx == 2'(c);
    assign lat_clr = (cw && ch_off == GPP_P_LAT_CLR) ? pwdata : GPP_RST_WORD;

    // Mask, edge and polarity through set and clear aliases
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pm_ff[c] <= GPP_RST_WORD;
        pe_ff[c] <= GPP_RST_WORD;
        pi_ff[c] <= GPP_RST_WORD;
      end else if (cw) begin
        case (ch_off)
          GPP_P_MASK_SET: pm_ff[c] <= pm_ff[c] | pwdata;
          GPP_P_MASK_CLR: pm_ff[c] <= pm_ff[c] & ~pwdata;
          GPP_P_EDGE_SET: pe_ff[c] <= pe_ff[c] | pwdata;
          GPP_P_EDGE_CLR: pe_ff[c] <= pe_ff[c] & ~pwdata;
          GPP_P_INV_SET:  pi_ff[c] <= pi_ff[c] | pwdata;
          GPP_P_INV_CLR:  pi_ff[c] <= pi_ff[c] & ~pwdata;
          default:        pm_ff[c] <= pm_ff[c];
        endcase
      end
    end

    // Sticky latch of assigned pins; set beats clear
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pl_ff[c] <= GPP_RST_WORD;
      end else begin
        pl_ff[c] <= (pl_ff[c] & ~lat_clr) | (pevt[c] & member[c]);
      end
    end

    // Channel request is the OR of unmasked latches
    assign pin_irq_channels[c] = |(pl_ff[c] & pm_ff[c]);
  end

  // ***************************************************************
  // Read mux and answer
  // ***************************************************************
  always_comb begin
    rdata = GPP_RST_WORD;
    hit   = 1'b1;
    if (in_page) begin
      unique case (ch_off)
        GPP_P_MASK:     rdata = pm_ff[ch_idx];
        GPP_P_REQ:      rdata = pl_ff[ch_idx] & pm_ff[ch_idx];
        GPP_P_LATCH:    rdata = pl_ff[ch_idx];
        GPP_P_EDGE:     rdata = pe_ff[ch_idx];
        GPP_P_INV:      rdata = pi_ff[ch_idx];
        GPP_P_PINS:     rdata = (pin_in ^ pi_ff[ch_idx])
                              & member[ch_idx];
        GPP_P_MASK_SET, GPP_P_MASK_CLR, GPP_P_LAT_CLR,
        GPP_P_EDGE_SET, GPP_P_EDGE_CLR,
        GPP_P_INV_SET,  GPP_P_INV_CLR: rdata = GPP_RST_WORD;
        default:        hit   = 1'b0;
      endcase
    end else begin
      unique case (paddr)
        GPP_DIR:        rdata = dir_ff;
        GPP_DOUT:       rdata = dout_ff;
        GPP_DIN:        rdata = pin_in;
        GPP_IRQ_STAT:   rdata = stat_ff;
        GPP_IRQ_EN:     rdata = en_ff;
        GPP_SENS_EDGE:  rdata = sedge_ff;
        GPP_SENS_BOTH:  rdata = sboth_ff;
        GPP_POL:        rdata = pol_ff;
        GPP_ASSIGN:     rdata = {24'h000000, assign_ff};
        GPP_DIR_SET, GPP_DIR_CLR, GPP_DOUT_SET, GPP_DOUT_CLR,
        GPP_DOUT_TGL, GPP_IRQ_CLR, GPP_IRQ_EN_SET,
        GPP_IRQ_EN_CLR, GPP_SWREQ: rdata = GPP_RST_WORD;
        default:        hit   = 1'b0;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_ff <= GPP_RST_WORD;
    end else if (rd_setup) begin
      prdata_ff <= rdata;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_dir_set_keep: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_en && paddr == GPP_DIR_SET) |=>
      ((dir_ff ^ $past(dir_ff)) & ~$past(pwdata)) == 32'h0000_0000
      && (dir_ff & $past(pwdata)) == $past(pwdata))
    else $error("direction set alias touched other pins");

  a_dir_drive: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_en && paddr == GPP_DIR) |=> pin_oe_n == ~$past(pwdata))
    else $error("pin enables do not follow direction write");

  a_mask_gate: assert property (
    @(posedge clk) disable iff (!arst_n)
    (en_ff == 32'h0000_0000) |-> !gpio_irq)
    else $error("port interrupt raised with all masks off");

  a_out_no_hw: assert property (
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> (stat_ff & ~$past(stat_ff) & $past(dir_ff)
      & ~$past(sw_req)) == 32'h0000_0000)
    else $error("output pin raised a hardware interrupt");

  a_rise_event: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sedge_ff[16] && !pol_ff[16] && !dir_ff[16] && $rose(pin_in[16]))
      |=> stat_ff[16])
    else $error("rising edge on pin 16 not latched");

  a_pint_level: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!pe_ff[0][6] && (pin_in[6] ^ pi_ff[0][6])
      && assign_ff[1:0] == 2'h0) |=> pl_ff[0][6])
    else $error("level request on pin 6 not latched");

  a_unassigned: assert property (
    @(posedge clk) disable iff (!arst_n)
    (assign_ff[1:0] != 2'h0) |=>
      (pl_ff[0][7:0] & ~$past(pl_ff[0][7:0])) == 8'h00)
    else $error("unassigned half port set a channel latch");

  a_latch_sticky: assert property (
    @(posedge clk) disable iff (!arst_n)
    (pl_ff[1][8] && !(wr_en && in_page && ch_idx == 2'h1
      && ch_off == GPP_P_LAT_CLR)) |=> pl_ff[1][8])
    else $error("latch dropped without a clear");

  a_mask_clr: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_en && in_page && ch_idx == 2'h1 && ch_off == GPP_P_MASK_CLR)
      |=> (pm_ff[1] & $past(pwdata)) == 32'h0000_0000)
    else $error("mask clear alias left bits set");

  a_latch_read: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd_setup && in_page && ch_idx == 2'h2 && ch_off == GPP_P_LATCH)
      |=> prdata == $past(pl_ff[2]))
    else $error("latch readback wrong");

  a_chan_req: assert property (
    @(posedge clk) disable iff (!arst_n)
    (pm_ff[1][8] && member[1][8] && pevt[1][8]
      && !(wr_en && in_page && ch_idx == 2'h1
      && ch_off == GPP_P_MASK_CLR)) |=> pin_irq_channels[1])
    else $error("unmasked pin event did not raise its channel");

endmodule // gpp_port

// ---- pkg/gpp_pkg.sv ----
// Register map, reset values and widths of the port and pin interrupt block
package gpp_pkg;

  localparam int          GPP_PINS       = 32;
  localparam int          GPP_HALF       = 8;
  localparam int          GPP_NHALF      = 4;
  localparam int          GPP_NCH        = 3;

  // ***************************************************************
  // Port registers (byte addresses)
  // ***************************************************************
  localparam logic [11:0] GPP_DIR        = 12'h000;
  localparam logic [11:0] GPP_DIR_SET    = 12'h004;
  localparam logic [11:0] GPP_DIR_CLR    = 12'h008;
  localparam logic [11:0] GPP_DOUT       = 12'h00C;
  localparam logic [11:0] GPP_DOUT_SET   = 12'h010;
  localparam logic [11:0] GPP_DOUT_CLR   = 12'h014;
  localparam logic [11:0] GPP_DOUT_TGL   = 12'h018;
  localparam logic [11:0] GPP_DIN        = 12'h01C;
  localparam logic [11:0] GPP_IRQ_STAT   = 12'h020;
  localparam logic [11:0] GPP_IRQ_CLR    = 12'h024;
  localparam logic [11:0] GPP_IRQ_EN     = 12'h028;
  localparam logic [11:0] GPP_IRQ_EN_SET = 12'h02C;
  localparam logic [11:0] GPP_IRQ_EN_CLR = 12'h030;
  localparam logic [11:0] GPP_SENS_EDGE  = 12'h034;
  localparam logic [11:0] GPP_SENS_BOTH  = 12'h038;
  localparam logic [11:0] GPP_POL        = 12'h03C;
  localparam logic [11:0] GPP_SWREQ      = 12'h040;
  localparam logic [11:0] GPP_ASSIGN     = 12'h044;

  // ***************************************************************
  // Pin interrupt channel registers (page, then offset in channel)
  // ***************************************************************
  localparam logic [3:0]  GPP_PINT_PAGE  = 4'h1;
  localparam logic [5:0]  GPP_P_MASK     = 6'h00;
  localparam logic [5:0]  GPP_P_MASK_SET = 6'h04;
  localparam logic [5:0]  GPP_P_MASK_CLR = 6'h08;
  localparam logic [5:0]  GPP_P_REQ      = 6'h0C;
  localparam logic [5:0]  GPP_P_LATCH    = 6'h10;
  localparam logic [5:0]  GPP_P_LAT_CLR  = 6'h14;
  localparam logic [5:0]  GPP_P_EDGE_SET = 6'h18;
  localparam logic [5:0]  GPP_P_EDGE_CLR = 6'h1C;
  localparam logic [5:0]  GPP_P_EDGE     = 6'h20;
  localparam logic [5:0]  GPP_P_INV_SET  = 6'h24;
  localparam logic [5:0]  GPP_P_INV_CLR  = 6'h28;
  localparam logic [5:0]  GPP_P_INV      = 6'h2C;
  localparam logic [5:0]  GPP_P_PINS     = 6'h30;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [31:0] GPP_RST_WORD   = 32'h0000_0000;
  localparam logic [7:0]  GPP_RST_ASSIGN = 8'hFF;
  localparam logic [1:0]  GPP_CH_NONE    = 2'h3;

endpackage

// ---- hw/gpp_pin_evt.sv ----
// Per-pin event detector: polarity, level or edge, one or both edges
`timescale 1ns/1ps
module gpp_pin_evt
  import gpp_pkg::*;
(
  input  wire logic pin_now,
  input  wire logic pin_prev,
  input  wire logic invert,
  input  wire logic edge_mode,
  input  wire logic both_edges,
  output logic      evt
);

  logic act_now;
  logic act_prev;
  logic rise;
  logic fall;

  // Polarity first, then edges of the active level
  assign act_now  = pin_now ^ invert;
  assign act_prev = pin_prev ^ invert;
  assign rise     = act_now & ~act_prev;
  assign fall     = ~act_now & act_prev;

  // Level mode follows the active level
  always_comb begin
    if (edge_mode) begin
      evt = rise | (both_edges & fall);
    end else begin
      evt = act_now;
    end
  end

endmodule // gpp_pin_evt

// ---- verif/gpp_ext_dev.sv ----
// Model of the external devices wired to the port pins
`timescale 1ns/1ps
module gpp_ext_dev
  import gpp_pkg::*;
(
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe_n,
  input  wire logic [31:0] ext_val,
  output logic [31:0]      pin_in
);
  // Wire level: device output where it drives, outside level elsewhere
  always_comb begin
    for (int i = 0; i < GPP_PINS; i++) begin
      pin_in[i] = pin_oe_n[i] ? ext_val[i] : pin_out[i];
    end
  end
endmodule // gpp_ext_dev

// ---- verif/gpp_port_tb.sv ----
// Self-checking bench for the port and pin interrupt block
`timescale 1ns/1ps
`define CHK(g, e) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); \
  end \
end
module gpp_port_tb;
  import gpp_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe_n;
  logic        gpio_irq;
  logic [2:0]  pin_irq_channels;
  logic [31:0] ext;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches;
  int          checks_done;
  int          cycles;

  // ***************************************************************
  // Clock, design and pin model
  // ***************************************************************
  always #10 clk = ~clk;

  gpp_port gpp_port_i (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .gpio_irq(gpio_irq),
    .pin_irq_channels(pin_irq_channels)
  );

  gpp_ext_dev gpp_ext_dev_i (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext),
    .pin_in(pin_in)
  );

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard over the whole run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // One APB transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdat, e)
    `CHK(rerr, 1'b0)
  endtask

  // Outside level of one pin, then time for sampling and latching
  task automatic pin(input int b, input logic v);
    @(posedge clk);
    ext[b] <= v;
    repeat (3) @(posedge clk);
  endtask

  task automatic irq(input logic g, input logic [2:0] c);
    @(posedge clk);
    #1;
    `CHK(gpio_irq, g)
    `CHK(pin_irq_channels, c)
  endtask

  function automatic logic [11:0] ca(input int c, input logic [5:0] o);
    return {GPP_PINT_PAGE, 2'(c), o};
  endfunction

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext = 32'h0000_0000;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    // Reset state and direction control
    rc(GPP_DIR, GPP_RST_WORD);
    rc(GPP_ASSIGN, {24'h00_0000, GPP_RST_ASSIGN});
    `CHK(pin_oe_n, 32'hFFFF_FFFF)
    wr(GPP_DIR_SET, 32'h0000_00F0);
    wr(GPP_DIR_CLR, 32'h0000_0030);
    rc(GPP_DIR, 32'h0000_00C0);
    `CHK(pin_oe_n, 32'hFFFF_FF3F)
    wr(GPP_DIR, 32'h0000_00C0);
    rc(GPP_DIR, 32'h0000_00C0);
    wr(GPP_DOUT_SET, 32'h0000_00FF);
    wr(GPP_DOUT_CLR, 32'h0000_000F);
    wr(GPP_DOUT_TGL, 32'h0000_0011);
    rc(GPP_DOUT, 32'h0000_00E1);
    `CHK(pin_out, 32'h0000_00E1)
    wr(GPP_DOUT, 32'h0000_0040);
    rc(GPP_DOUT, 32'h0000_0040);
    rc(GPP_DIN, 32'h0000_0040);
    wr(GPP_DOUT, 32'h0000_00E1);
    rc(GPP_IRQ_STAT, 32'h0000_0000);
    // Unmapped address is refused
    apb(1'b0, 12'h1C0, 32'h0000_0000);
    `CHK(rerr, 1'b1)
    `CHK(rdat, 32'h0000_0000)
    // Port edge detection, rising only then both edges
    wr(GPP_SENS_EDGE, 32'h0001_0000);
    wr(GPP_IRQ_EN, 32'h0001_0000);
    pin(16, 1'b1);
    rc(GPP_IRQ_STAT, 32'h0001_0000);
    irq(1'b1, 3'h0);
    wr(GPP_IRQ_CLR, 32'h0001_0000);
    pin(16, 1'b0);
    rc(GPP_IRQ_STAT, 32'h0000_0000);
    wr(GPP_SENS_BOTH, 32'h0001_0000);
    pin(16, 1'b1);
    wr(GPP_IRQ_CLR, 32'h0001_0000);
    pin(16, 1'b0);
    rc(GPP_IRQ_STAT, 32'h0001_0000);
    wr(GPP_IRQ_CLR, 32'h0001_0000);
    // Active-low polarity: only the falling pin edge counts
    wr(GPP_SENS_BOTH, 32'h0000_0000);
    wr(GPP_POL, 32'h0001_0000);
    pin(16, 1'b1);
    rc(GPP_IRQ_STAT, 32'h0000_0000);
    pin(16, 1'b0);
    rc(GPP_IRQ_STAT, 32'h0001_0000);
    wr(GPP_IRQ_CLR, 32'h0001_0000);
    wr(GPP_POL, 32'h0000_0000);
    // Port level mode and masking
    wr(GPP_IRQ_EN_SET, 32'h0002_0000);
    rc(GPP_IRQ_EN, 32'h0003_0000);
    pin(17, 1'b1);
    wr(GPP_IRQ_CLR, 32'h0002_0000);
    rc(GPP_IRQ_STAT, 32'h0002_0000);
    wr(GPP_IRQ_EN_CLR, 32'h0003_0000);
    irq(1'b0, 3'h0);
    rc(GPP_IRQ_STAT, 32'h0002_0000);
    pin(17, 1'b0);
    wr(GPP_IRQ_CLR, 32'h0002_0000);
    rc(GPP_IRQ_STAT, 32'h0000_0000);
    // Software requests reach output pins only
    wr(GPP_SWREQ, 32'h0001_0080);
    rc(GPP_IRQ_STAT, 32'h0000_0080);
    wr(GPP_IRQ_EN_SET, 32'h0000_0080);
    irq(1'b1, 3'h0);
    wr(GPP_IRQ_CLR, 32'h0000_0080);
    irq(1'b0, 3'h0);
    // Pin interrupt channels: half 0 to channel 0, half 1 to channel 1
    wr(GPP_ASSIGN, 32'h0000_00F4);
    rc(ca(0, GPP_P_LATCH), 32'h0000_00C0);
    rc(ca(0, GPP_P_REQ), 32'h0000_0000);
    wr(ca(1, GPP_P_EDGE_SET), 32'h0000_0100);
    wr(ca(1, GPP_P_MASK_SET), 32'h0000_0100);
    rc(ca(1, GPP_P_EDGE), 32'h0000_0100);
    rc(ca(1, GPP_P_MASK), 32'h0000_0100);
    pin(8, 1'b1);
    rc(ca(1, GPP_P_LATCH), 32'h0000_0100);
    rc(ca(1, GPP_P_REQ), 32'h0000_0100);
    irq(1'b0, 3'h2);
    pin(8, 1'b0);
    rc(ca(1, GPP_P_LATCH), 32'h0000_0100);
    rc(ca(2, GPP_P_LATCH), 32'h0000_0000);
    rc(ca(0, GPP_P_LATCH), 32'h0000_00C0);
    wr(ca(1, GPP_P_LAT_CLR), 32'h0000_0100);
    irq(1'b0, 3'h0);
    // Level mode, active low, then masked readback
    wr(ca(1, GPP_P_EDGE_CLR), 32'h0000_0100);
    wr(ca(1, GPP_P_INV_SET), 32'h0000_0100);
    rc(ca(1, GPP_P_EDGE), 32'h0000_0000);
    rc(ca(1, GPP_P_INV), 32'h0000_0100);
    rc(ca(1, GPP_P_LATCH), 32'h0000_0100);
    rc(ca(1, GPP_P_PINS), 32'h0000_0100);
    wr(ca(1, GPP_P_MASK_CLR), 32'h0000_0100);
    rc(ca(1, GPP_P_REQ), 32'h0000_0000);
    rc(ca(1, GPP_P_LATCH), 32'h0000_0100);
    irq(1'b0, 3'h0);
    summarize();
  end
endmodule // gpp_port_tb
